/* File: include/i2c_slave_pkg.sv */
// constants, types and state layouts of the two-wire serial slave controller
// Overview of operation
// - ninth clock samples master acknowledge into flag
// - transmitter releases data line after missing acknowledge
// - seven address bits follow start, msb first
// - address match sets addressed flag, raises interrupt
// - eighth bit stored as master read request
// - interrupt on match, byte done or timeout
// - slave only with mode 110 and enabled
// - own address register used for every comparison
// - interrupt needs both enable bits set
// - every start detected, address reception prepared
// - status resets to byte-complete and no-acknowledge set
// - matched address acknowledged low on ninth bit
// - clock held low until software services data
// - start condition sets bus busy flag
package i2c_slave_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFS_CTRL = 3'h0;
    localparam logic [2:0] OFS_OWN = 3'h1;
    localparam logic [2:0] OFS_STAT = 3'h2;
    localparam logic [2:0] OFS_DATA = 3'h3;
    localparam logic [2:0] OFS_IEN = 3'h4;
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_I2C_SLAVE = 3'h6;
    localparam int CTRL_MODE_LSB = 5;
    localparam int CTRL_EN = 1;
    localparam logic [7:0] CTRL_RST = 8'he0;
    localparam logic [7:0] CTRL_WMASK = 8'hef;
    localparam int ST_DONE = 7;
    localparam int ST_MATCHED = 6;
    localparam int ST_BUSY = 5;
    localparam int ST_XMIT = 4;
    localparam int ST_NACK_SEL = 3;
    localparam int ST_READ_REQ = 2;
    localparam int ST_WAKE = 1;
    localparam int ST_ACK_IN = 0;
    localparam logic [7:0] STAT_RST = 8'h81;
    localparam logic [7:0] STAT_WMASK = 8'h1e;
    localparam int IEN_SIE = 0;
    localparam int IEN_MFE = 1;
    localparam int IEN_TOF = 2;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_ACK_END = 4'h9;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        L_IDLE = 3'b000,
        L_ADDR = 3'b001,
        L_AACK = 3'b010,
        L_HOLD = 3'b011,
        L_TX = 3'b100,
        L_TXACK = 3'b101,
        L_RX = 3'b110,
        L_RXACK = 3'b111
    } link_st_t;

    // settings carried into the link domain
    typedef struct packed {
        logic active;
        logic nack_sel;
        logic [6:0] own;
    } link_cfg_t;

    // system domain state
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] own;
        logic [7:0] stat;
        logic [7:0] data;
        logic [2:0] ien;
        logic [7:0] rdata;
        logic rel_tgl;
        logic act_d;
        logic irq;
    } sys_state_t;

    // link domain state
    typedef struct packed {
        link_st_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] rx_byte;
        logic rw;
        logic ack_in;
        logic sda_low;
        logic scl_low;
        logic scl_p;
        logic sda_p;
        logic start_tgl;
        logic stop_tgl;
        logic match_tgl;
        logic byte_tgl;
    } link_state_t;
endpackage : i2c_slave_pkg

/* File: verilog/sync2.sv */
// two flip-flop level synchroniser for a bundle of quasi-static bits
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // destination clock
    input wire logic clk,
    input wire logic reset,
    // level in and out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (WIDTH < 1)
    begin : g_bad
        $error("sync2 width must be at least one");
    end

    // first stage feeds only the second stage
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            meta_r <= RST_VAL;
            q_r <= RST_VAL;
        end
        else
        begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule : sync2
`default_nettype wire

/* File: verilog/toggle_pulse.sv */
// toggle to one-cycle pulse crossing into the destination clock
`timescale 1ns/1ps
`default_nettype none
module toggle_pulse (
    // destination clock
    input wire logic clk,
    input wire logic reset,
    // toggle from the source domain, pulse out
    input wire logic tgl,
    output logic pulse
);
    logic [2:0] sh_r;

    // two sync stages then an edge stage
    always_ff @(posedge clk)
    begin
        if (reset)
            sh_r <= 3'h0;
        else
            sh_r <= {sh_r[1:0], tgl};
    end

    assign pulse = sh_r[2] ^ sh_r[1];
endmodule : toggle_pulse
`default_nettype wire

/* File: verilog/i2c_slave_status_control.sv */
// two-wire serial slave: registers, status flags and link engine
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_status_control (
    // system clock and reset
    input wire logic clk,
    input wire logic reset,
    // link sampling clock
    input wire logic link_clk,
    // register port
    input wire logic [i2c_slave_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // time-out event from the bus time-out counter
    input wire logic timeout_event,
    // interrupt request to the processor
    output logic serial_irq,
    // open-drain bus pins
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);
    i2c_slave_pkg::sys_state_t r, n;
    i2c_slave_pkg::link_state_t lr, ln;
    i2c_slave_pkg::link_cfg_t cfg_s, cfg_l;
    logic link_reset;
    logic scl_s, sda_s;
    logic rel_p, start_p, stop_p, match_p, byte_p;
    logic active, rise, fall, start_c, stop_c;
    logic [7:0] sh_in;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic mode_active(input logic [7:0] ctrl);
        mode_active = (ctrl[i2c_slave_pkg::CTRL_MODE_LSB +: 3] == i2c_slave_pkg::MODE_I2C_SLAVE)
            && ctrl[i2c_slave_pkg::CTRL_EN];
    endfunction : mode_active

    // ------------------------------------------------------------
    // crossings
    // ------------------------------------------------------------
    // reset and pins into the link domain
    sync2 #(.WIDTH(3), .RST_VAL(3'h7)) u_pin_sync (
        .clk(link_clk),
        .reset(1'b0),
        .d({reset, scl_in, sda_in}),
        .q({link_reset, scl_s, sda_s})
    );

    // settings are resynchronised every cycle, whatever phase the link is in
    assign cfg_s = '{active: mode_active(r.ctrl), nack_sel: r.stat[i2c_slave_pkg::ST_NACK_SEL], own: r.own[7:1]};
    sync2 #(.WIDTH(9), .RST_VAL(9'h000)) u_cfg_sync (
        .clk(link_clk),
        .reset(link_reset),
        .d(cfg_s),
        .q(cfg_l)
    );

    toggle_pulse u_rel (.clk(link_clk), .reset(link_reset), .tgl(r.rel_tgl), .pulse(rel_p));
    toggle_pulse u_start (.clk(clk), .reset(reset), .tgl(lr.start_tgl), .pulse(start_p));
    toggle_pulse u_stop (.clk(clk), .reset(reset), .tgl(lr.stop_tgl), .pulse(stop_p));
    toggle_pulse u_match (.clk(clk), .reset(reset), .tgl(lr.match_tgl), .pulse(match_p));
    toggle_pulse u_byte (.clk(clk), .reset(reset), .tgl(lr.byte_tgl), .pulse(byte_p));

    // ------------------------------------------------------------
    // system domain: registers and flags
    // ------------------------------------------------------------
    assign active = mode_active(r.ctrl);

    // register access, release requests and link events
    always_comb
    begin
        logic ev;
        ev = 1'b0;
        n = r;
        n.act_d = active;
        // flags other than transmit, no-ack select and wake go to defaults when the interface is switched on
        if (active && !r.act_d)
        begin
            n.stat[i2c_slave_pkg::ST_DONE] = 1'b1;
            n.stat[i2c_slave_pkg::ST_MATCHED] = 1'b0;
            n.stat[i2c_slave_pkg::ST_BUSY] = 1'b0;
            n.stat[i2c_slave_pkg::ST_READ_REQ] = 1'b0;
            n.stat[i2c_slave_pkg::ST_ACK_IN] = 1'b1;
        end
        // software writes
        if (reg_wr)
        begin
            case (reg_addr)
                i2c_slave_pkg::OFS_CTRL: n.ctrl = reg_wdata & i2c_slave_pkg::CTRL_WMASK;
                i2c_slave_pkg::OFS_OWN: n.own = reg_wdata;
                i2c_slave_pkg::OFS_STAT:
                    n.stat = (r.stat & ~i2c_slave_pkg::STAT_WMASK) | (reg_wdata & i2c_slave_pkg::STAT_WMASK);
                i2c_slave_pkg::OFS_DATA:
                begin
                    n.data = reg_wdata;
                    if (r.stat[i2c_slave_pkg::ST_XMIT])
                    begin
                        n.rel_tgl = ~r.rel_tgl;
                        n.stat[i2c_slave_pkg::ST_DONE] = 1'b0;
                    end
                end
                i2c_slave_pkg::OFS_IEN: n.ien = reg_wdata[2:0];
                default: ;
            endcase
        end
        // software reads, data valid the next cycle only
        n.rdata = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                i2c_slave_pkg::OFS_CTRL: n.rdata = r.ctrl;
                i2c_slave_pkg::OFS_OWN: n.rdata = r.own;
                i2c_slave_pkg::OFS_STAT: n.rdata = r.stat;
                i2c_slave_pkg::OFS_DATA:
                begin
                    n.rdata = r.data;
                    if (!r.stat[i2c_slave_pkg::ST_XMIT])
                    begin
                        n.rel_tgl = ~r.rel_tgl;
                        n.stat[i2c_slave_pkg::ST_DONE] = 1'b0;
                    end
                end
                i2c_slave_pkg::OFS_IEN: n.rdata = {5'h00, r.ien};
                default: n.rdata = 8'h00;
            endcase
        end
        // hardware events come last so they beat a software write in the same cycle
        if (start_p)
        begin
            n.stat[i2c_slave_pkg::ST_BUSY] = 1'b1;
            n.stat[i2c_slave_pkg::ST_MATCHED] = 1'b0;
        end
        if (stop_p)
            n.stat[i2c_slave_pkg::ST_BUSY] = 1'b0;
        if (match_p)
        begin
            n.stat[i2c_slave_pkg::ST_MATCHED] = 1'b1;
            n.stat[i2c_slave_pkg::ST_READ_REQ] = lr.rw;
            n.stat[i2c_slave_pkg::ST_DONE] = 1'b1;
            ev = 1'b1;
        end
        if (byte_p)
        begin
            n.stat[i2c_slave_pkg::ST_DONE] = 1'b1;
            n.stat[i2c_slave_pkg::ST_MATCHED] = 1'b0;
            n.stat[i2c_slave_pkg::ST_ACK_IN] = lr.ack_in;
            if (!r.stat[i2c_slave_pkg::ST_XMIT])
                n.data = lr.rx_byte;
            ev = 1'b1;
        end
        if (timeout_event && active)
        begin
            n.stat = i2c_slave_pkg::STAT_RST;
            n.ien[i2c_slave_pkg::IEN_TOF] = 1'b1;
            ev = 1'b1;
        end
        n.irq = ev && r.ien[i2c_slave_pkg::IEN_SIE] && r.ien[i2c_slave_pkg::IEN_MFE];
    end

    // system state register
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            r <= '0;
            r.ctrl <= i2c_slave_pkg::CTRL_RST;
            r.stat <= i2c_slave_pkg::STAT_RST;
        end
        else
            r <= n;
    end

    assign reg_rdata = r.rdata;
    assign serial_irq = r.irq;

    // ------------------------------------------------------------
    // link domain: bit engine
    // ------------------------------------------------------------
    assign rise = scl_s && !lr.scl_p;
    assign fall = !scl_s && lr.scl_p;
    assign start_c = scl_s && lr.scl_p && lr.sda_p && !sda_s;
    assign stop_c = scl_s && lr.scl_p && !lr.sda_p && sda_s;
    assign sh_in = {lr.sh[6:0], sda_s};

    // start, address, acknowledge and data phases
    always_comb
    begin
        ln = lr;
        ln.scl_p = scl_s;
        ln.sda_p = sda_s;
        case (lr.st)
            i2c_slave_pkg::L_ADDR:
                if (rise)
                begin
                    ln.sh = sh_in;
                    ln.cnt = lr.cnt + 4'h1;
                    if (lr.cnt == i2c_slave_pkg::BIT_LAST)
                    begin
                        ln.rw = sda_s;
                        if (sh_in[7:1] == cfg_l.own)
                        begin
                            ln.st = i2c_slave_pkg::L_AACK;
                            ln.match_tgl = ~lr.match_tgl;
                        end
                        else
                            ln.st = i2c_slave_pkg::L_IDLE;
                    end
                end
            i2c_slave_pkg::L_AACK, i2c_slave_pkg::L_RXACK:
                if (fall && lr.cnt == i2c_slave_pkg::BIT_ACK)
                begin
                    ln.sda_low = (lr.st == i2c_slave_pkg::L_AACK) || !cfg_l.nack_sel;
                    ln.cnt = i2c_slave_pkg::BIT_ACK_END;
                end
                else if (fall)
                begin
                    ln.sda_low = 1'b0;
                    ln.scl_low = 1'b1;
                    ln.st = i2c_slave_pkg::L_HOLD;
                end
            i2c_slave_pkg::L_HOLD:
                if (rel_p)
                begin
                    ln.scl_low = 1'b0;
                    ln.cnt = 4'h0;
                    if (lr.rw)
                    begin
                        ln.sh = r.data;
                        ln.sda_low = !r.data[7];
                        ln.st = i2c_slave_pkg::L_TX;
                    end
                    else
                        ln.st = i2c_slave_pkg::L_RX;
                end
            i2c_slave_pkg::L_TX:
                if (rise)
                    ln.cnt = lr.cnt + 4'h1;
                else if (fall && lr.cnt == i2c_slave_pkg::BIT_ACK)
                begin
                    ln.sda_low = 1'b0;
                    ln.st = i2c_slave_pkg::L_TXACK;
                end
                else if (fall)
                begin
                    ln.sh = {lr.sh[6:0], 1'b0};
                    ln.sda_low = !lr.sh[6];
                end
            i2c_slave_pkg::L_TXACK:
                if (rise)
                begin
                    ln.ack_in = sda_s;
                    ln.byte_tgl = ~lr.byte_tgl;
                end
                else if (fall && lr.ack_in)
                    ln.st = i2c_slave_pkg::L_IDLE;
                else if (fall)
                begin
                    ln.scl_low = 1'b1;
                    ln.st = i2c_slave_pkg::L_HOLD;
                end
            i2c_slave_pkg::L_RX:
                if (rise)
                begin
                    ln.sh = sh_in;
                    ln.cnt = lr.cnt + 4'h1;
                    if (lr.cnt == i2c_slave_pkg::BIT_LAST)
                    begin
                        ln.rx_byte = sh_in;
                        ln.byte_tgl = ~lr.byte_tgl;
                        ln.st = i2c_slave_pkg::L_RXACK;
                    end
                end
            default: ;
        endcase
        // start and stop override every phase
        if (start_c)
        begin
            ln.start_tgl = ~lr.start_tgl;
            ln.st = i2c_slave_pkg::L_ADDR;
            ln.cnt = 4'h0;
            ln.sda_low = 1'b0;
            ln.scl_low = 1'b0;
        end
        if (stop_c)
        begin
            ln.stop_tgl = ~lr.stop_tgl;
            ln.st = i2c_slave_pkg::L_IDLE;
        end
        if (ln.st == i2c_slave_pkg::L_IDLE || !cfg_l.active)
        begin
            ln.st = i2c_slave_pkg::L_IDLE;
            ln.sda_low = 1'b0;
            ln.scl_low = 1'b0;
        end
    end

    // link state register
    always_ff @(posedge link_clk)
    begin
        if (link_reset)
        begin
            lr <= '0;
            lr.scl_p <= 1'b1;
            lr.sda_p <= 1'b1;
            lr.ack_in <= 1'b1;
        end
        else
            lr <= ln;
    end

    // pins only ever pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = lr.scl_low;
    assign sda_oe = lr.sda_low;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_status_reset: assert property (@(posedge clk) reset |=> r.stat == i2c_slave_pkg::STAT_RST)
        else $error("status not at reset value");
    chk_irq_enables: assert property (@(posedge clk) disable iff (reset)
        serial_irq |-> $past(r.ien[i2c_slave_pkg::IEN_SIE]) && $past(r.ien[i2c_slave_pkg::IEN_MFE]))
        else $error("interrupt without both enables");
    chk_match_flags: assert property (@(posedge clk) disable iff (reset)
        match_p && !start_p && !timeout_event |=> r.stat[i2c_slave_pkg::ST_MATCHED]
        && r.stat[i2c_slave_pkg::ST_READ_REQ] == $past(lr.rw))
        else $error("match flags not updated");
    chk_byte_done: assert property (@(posedge clk) disable iff (reset)
        byte_p && !timeout_event |=> r.stat[i2c_slave_pkg::ST_DONE])
        else $error("byte complete not set");
    chk_start_busy: assert property (@(posedge clk) disable iff (reset)
        start_p && !stop_p && !timeout_event |=> r.stat[i2c_slave_pkg::ST_BUSY])
        else $error("bus busy not set on start");
    chk_ack_drive: assert property (@(posedge link_clk) disable iff (link_reset)
        lr.st == i2c_slave_pkg::L_AACK && lr.cnt == i2c_slave_pkg::BIT_ACK_END |-> sda_oe)
        else $error("address acknowledge not driven");
    chk_hold_stretch: assert property (@(posedge link_clk) disable iff (link_reset)
        lr.st == i2c_slave_pkg::L_HOLD && !rel_p ##1 lr.st == i2c_slave_pkg::L_HOLD |-> scl_oe)
        else $error("clock not held while waiting");
    chk_nack_release: assert property (@(posedge link_clk) disable iff (link_reset)
        lr.st == i2c_slave_pkg::L_TXACK && fall && lr.ack_in && !start_c |=> !sda_oe && !scl_oe)
        else $error("data line kept after no acknowledge");
    chk_ack_sample: assert property (@(posedge link_clk) disable iff (link_reset)
        lr.st == i2c_slave_pkg::L_TXACK && rise && !start_c && !stop_c |=> lr.ack_in == $past(sda_s))
        else $error("acknowledge not sampled");
    chk_off_idle: assert property (@(posedge link_clk) disable iff (link_reset)
        !cfg_l.active |=> lr.st == i2c_slave_pkg::L_IDLE)
        else $error("engine active while disabled");
    chk_addr_match: assert property (@(posedge link_clk) disable iff (link_reset)
        lr.st == i2c_slave_pkg::L_ADDR && rise && lr.cnt == i2c_slave_pkg::BIT_LAST && cfg_l.active
        && sh_in[7:1] == cfg_l.own && !start_c && !stop_c |=> lr.st == i2c_slave_pkg::L_AACK)
        else $error("own address not recognised");

    cov_match: cover property (@(posedge clk) match_p);
    cov_rx_byte: cover property (@(posedge clk) byte_p && !r.stat[i2c_slave_pkg::ST_XMIT]);
    cov_tx_nack: cover property (@(posedge link_clk) lr.st == i2c_slave_pkg::L_TXACK && fall && lr.ack_in);
    cov_timeout: cover property (@(posedge clk) timeout_event && active);
endmodule : i2c_slave_status_control
`default_nettype wire

/* File: dv/i2c_master_model.sv */
// behavioural two-wire bus master on open-drain clock and data lines
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model #(
    parameter int HALF = 640
) (
    // wire levels
    input wire logic scl,
    input wire logic sda,
    // pull-downs of this master
    output logic scl_low,
    output logic sda_low
);
    // both lines released at time zero
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // release the clock, then wait out any stretching by the slave
    task automatic rise();
        scl_low = 1'b0;
        wait (scl === 1'b1);
        #HALF;
    endtask : rise
    // start: data falls while the clock is high
    task automatic start();
        sda_low = 1'b1;
        #HALF;
        scl_low = 1'b1;
        #(HALF/4);
    endtask : start
    // stop: data rises while the clock is high
    task automatic stop();
        sda_low = 1'b1;
        #HALF;
        rise();
        sda_low = 1'b0;
        #HALF;
    endtask : stop
    // nine bits msb first, a one releases the line; returns what the wire showed
    task automatic xfer(input logic [8:0] out, output logic [8:0] got);
        for (int i = 8; i >= 0; i--)
        begin
            sda_low = !out[i];
            #HALF;
            rise();
            got[i] = sda;
            scl_low = 1'b1;
            #(HALF/4);
        end
        sda_low = 1'b0;
    endtask : xfer
endmodule : i2c_master_model
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the two-wire serial slave controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic [7:0] own;
        logic [7:0] ien;
        logic [7:0] adr;
        logic ack;
        logic [7:0] st;
        logic [7:0] irqs;
    } row_t;
    // ------------------------------------------------------------
    // clocks, wires and the device
    // ------------------------------------------------------------
    logic clk = 1'b0, link_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, timeout_event = 1'b0;
    logic [i2c_slave_pkg::ADDR_W-1:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
    logic serial_irq, scl_oe, sda_oe, m_scl_low, m_sda_low, scl_o, sda_o;
    logic [8:0] g;
    int bad_count = 0, comparisons = 0, irq_n = 0, base = 0;
    row_t rows [5];
    logic [7:0] rst_exp [8] = '{8'he0, 8'h00, 8'h81, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] off_ctrl [3] = '{8'hc0, 8'he2, 8'ha2};
    wire logic scl = !(scl_oe | m_scl_low); // pulled up unless someone pulls low
    wire logic sda = !(sda_oe | m_sda_low);
    always #4 clk = ~clk;
    initial #13 forever #32 link_clk = ~link_clk;
    // count interrupt pulses
    always @(posedge clk) if (serial_irq === 1'b1) irq_n <= irq_n + 1;
    i2c_slave_status_control DUT (.clk(clk), .reset(reset), .link_clk(link_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .timeout_event(timeout_event), .serial_irq(serial_irq), .scl_in(scl), .scl_out(scl_o), .scl_oe(scl_oe),
        .sda_in(sda), .sda_out(sda_o), .sda_oe(sda_oe));
    i2c_master_model m (.scl(scl), .sda(sda), .scl_low(m_scl_low), .sda_low(m_sda_low));
    // register port cycles and comparisons
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
        rd(a, d);
        chk8(d, exp);
    endtask : rdc
    task automatic stop_test();
        $display("mismatches %0d, comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    // ------------------------------------------------------------
    // address table, then reset and awkward cases
    // ------------------------------------------------------------
    initial
    begin
        rows[0] = {8'ha4, 8'h03, 8'ha4, 1'b0, 8'h60, 8'h01};
        rows[1] = {8'ha4, 8'h03, 8'ha6, 1'b1, 8'h20, 8'h00};
        rows[2] = {8'ha4, 8'h03, 8'h24, 1'b1, 8'h20, 8'h00};
        rows[3] = {8'h14, 8'h01, 8'h14, 1'b0, 8'h60, 8'h00};
        rows[4] = {8'hfe, 8'h03, 8'hfe, 1'b0, 8'h60, 8'h01};
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        // let the link side leave reset before the first frame
        repeat (40) @(posedge clk);
        wr(3'h0, 8'hc2);
        foreach (rows[i])
        begin
            base = irq_n;
            wr(3'h1, rows[i].own);
            wr(3'h4, rows[i].ien);
            m.start();
            m.xfer({rows[i].adr, 1'b1}, g);
            chk1(g[0], rows[i].ack);
            rd(3'h2, d);
            chk8(d & 8'h64, rows[i].st);
            chk8(8'(irq_n - base), rows[i].irqs);
            rd(3'h3, d);
            m.stop();
        end
        reset <= 1'b1;
        repeat (40) @(posedge clk);
        reset <= 1'b0;
        wr(3'h7, 8'hff);
        foreach (rst_exp[i]) rdc(3'(i), rst_exp[i]);
        wr(3'h2, 8'hff);
        rdc(3'h2, 8'h1f);
        wr(3'h2, 8'h00);
        wr(3'h1, 8'ha4);
        for (int i = 0; i < 3; i++)
        begin
            wr(3'h0, off_ctrl[i]);
            m.start();
            m.xfer({8'ha4, 1'b1}, g);
            chk1(g[0], 1'b1);
            m.stop();
        end
        wr(3'h0, 8'hc2);
        wr(3'h4, 8'h03);
        base = irq_n;
        m.start();
        m.xfer({8'ha4, 1'b1}, g);
        #2000;
        chk1(scl, 1'b0);
        chk1(scl_o | sda_o, 1'b0);
        rd(3'h3, d);
        rd(3'h2, d);
        chk1(d[7], 1'b0);
        m.xfer({8'h3c, 1'b1}, g);
        chk1(g[0], 1'b0);
        rd(3'h2, d);
        chk1(d[7], 1'b1);
        rdc(3'h3, 8'h3c);
        chk8(8'(irq_n - base), 8'h02);
        // receive one byte with the acknowledge withheld
        wr(3'h2, 8'h08);
        m.xfer({8'h00, 1'b1}, g);
        chk1(g[0], 1'b1);
        rdc(3'h3, 8'h00);
        wr(3'h2, 8'h00);
        m.stop();
        m.start();
        m.xfer({8'ha5, 1'b1}, g);
        rdc(3'h2, 8'he5);
        wr(3'h2, 8'h10);
        wr(3'h3, 8'h96);
        m.xfer({8'hff, 1'b0}, g);
        chk8(g[8:1], 8'h96);
        rd(3'h2, d);
        chk1(d[0], 1'b0);
        wr(3'h3, 8'h5a);
        m.xfer(9'h1ff, g);
        chk8(g[8:1], 8'h5a);
        rd(3'h2, d);
        chk1(d[0], 1'b1);
        #2000;
        chk1(sda, 1'b1);
        m.stop();
        base = irq_n;
        @(posedge clk);
        timeout_event <= 1'b1;
        @(posedge clk);
        timeout_event <= 1'b0;
        repeat (4) @(posedge clk);
        chk8(8'(irq_n - base), 8'h01);
        rdc(3'h4, 8'h07);
        rdc(3'h2, 8'h81);
        stop_test();
    end
    // watchdog against a hung bus
    initial
    begin
        #600000;
        bad_count++;
        stop_test();
    end
endmodule : testbench
`default_nettype wire
